// ===== deep_sleep_clock_gate_bank_one.sv
`timescale 1ns/1ps

// Behaviour
// - A set gate bit clocks its unit and a clear one stops the clock and holds the unit off.
// - Any access to a unit whose clock is gated off ends in a bus fault instead of completing.
// - The deep-sleep gate register sits at offset 0x124 and resets to 0x00000000, all units unclocked.
// - Run, sleep and deep-sleep gate registers exist in parallel and the auto-gating bit selects the sleep or deep-sleep ones in those modes.
// - Bit 24 is a read-write gate for the first analog comparator.
// - Bits 18, 17 and 16 are read-write gates for general-purpose counters two, one and zero.
// - Bit 12 is a read-write gate for the two-wire serial unit.
// - Bit 4 is a read-write gate for the synchronous serial unit.
// - Bits 1 and 0 are read-write gates for asynchronous serial units one and zero.
// - Reserved bits 31:25, 23:19, 15:13, 11:5 and 3:2 are read-only zero and software writes back what it read.
module deep_sleep_clock_gate_bank_one
  import clk_gate_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADDR_W-1:0]     wb_adr_i,
  input  wire logic [SEL_W-1:0]      wb_sel_i,
  input  wire logic [DATA_W-1:0]     wb_dat_i,
  output logic      [DATA_W-1:0]     wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire logic                  sleepMode,
  input  wire logic                  deepSleepMode,
  output logic      [DATA_W-1:0]     unitClkEn,
  input  wire logic                  accReq,
  input  wire logic [UNIT_IDX_W-1:0] accUnit,
  output logic                       accGrant,
  output logic                       accFault
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    bus_state_t  busState;
    logic        ack;
    logic        err;
    logic [31:0] datOut;
    logic [31:0] runGate;
    logic [31:0] sleepGate;
    logic [31:0] deepGate;
    logic        autoGating;
    logic [31:0] gateEn;
  } gate_state_t;

  localparam gate_state_t STATE_RESET = '{
    busState:   BUS_IDLE,
    ack:        1'b0,
    err:        1'b0,
    datOut:     32'h0000_0000,
    runGate:    GATE_RESET,
    sleepGate:  GATE_RESET,
    deepGate:   GATE_RESET,
    autoGating: AUTO_GATE_RESET,
    gateEn:     GATE_RESET
  };

  gate_state_t          stateReg;
  gate_state_t          stateNext;
  logic                 busReq;
  logic                 hitRun;
  logic                 hitSleep;
  logic                 hitDeep;
  logic                 hitCfg;
  logic                 hitStatus;
  logic                 mapped;
  logic                 writeNow;
  logic [31:0]          rdWord;
  logic [31:0]          selGate;
  logic [UNIT_COUNT-1:0] unitGate;

  // ****************************************************************
  // gate selection
  // ****************************************************************
  // deep sleep outranks sleep when both mode inputs are high
  function automatic logic [31:0] select_gate(input logic [31:0] runG,
                                              input logic [31:0] sleepG,
                                              input logic [31:0] deepG,
                                              input logic        autoG,
                                              input logic        sleepM,
                                              input logic        deepM);
    if (autoG && deepM) begin
      select_gate = deepG;
    end else if (autoG && sleepM) begin
      select_gate = sleepG;
    end else begin
      select_gate = runG;
    end
  endfunction : select_gate

  function automatic logic word_hit(input logic [11:0] adr, input logic [11:0] off);
    word_hit = (adr[11:2] == off[11:2]);
  endfunction : word_hit

  // ****************************************************************
  // address decode
  // ****************************************************************
  always_comb begin
    busReq    = wb_cyc_i && wb_stb_i;
    hitRun    = word_hit(wb_adr_i, RUN_GATE_OFF);
    hitSleep  = word_hit(wb_adr_i, SLEEP_GATE_OFF);
    hitDeep   = word_hit(wb_adr_i, DEEP_GATE_OFF);
    hitCfg    = word_hit(wb_adr_i, RUN_CFG_OFF);
    hitStatus = word_hit(wb_adr_i, GATE_STATUS_OFF);
    mapped    = hitRun || hitSleep || hitDeep || hitCfg || hitStatus;
    writeNow  = (stateReg.busState == BUS_ANSWER) && stateReg.ack && busReq && wb_we_i;
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rdWord = 32'h0000_0000;
    if (hitRun) begin
      rdWord = stateReg.runGate & GATE_IMPL_MASK;
    end else if (hitSleep) begin
      rdWord = stateReg.sleepGate & GATE_IMPL_MASK;
    end else if (hitDeep) begin
      rdWord = stateReg.deepGate & GATE_IMPL_MASK;
    end else if (hitCfg) begin
      rdWord[AUTO_GATING_BIT] = stateReg.autoGating;
    end else if (hitStatus) begin
      rdWord = stateReg.gateEn;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    stateNext     = stateReg;
    stateNext.ack = 1'b0;
    stateNext.err = 1'b0;
    selGate       = select_gate(stateReg.runGate, stateReg.sleepGate, stateReg.deepGate,
                                stateReg.autoGating, sleepMode, deepSleepMode);
    // unimplemented positions never carry a clock enable
    stateNext.gateEn = selGate & GATE_IMPL_MASK;
    case (stateReg.busState)
      BUS_IDLE: begin
        if (busReq) begin
          stateNext.busState = BUS_ANSWER;
          if (mapped) begin
            stateNext.ack    = 1'b1;
            stateNext.datOut = rdWord;
          end else begin
            stateNext.err    = 1'b1;
            stateNext.datOut = 32'h0000_0000;
          end
        end
      end
      BUS_ANSWER: begin
        // write lands on the edge at which the master samples ack
        stateNext.busState = BUS_IDLE;
        if (writeNow) begin
          if (hitRun) begin
            stateNext.runGate = byte_merge(stateReg.runGate, wb_dat_i, wb_sel_i) & GATE_IMPL_MASK;
          end
          if (hitSleep) begin
            stateNext.sleepGate = byte_merge(stateReg.sleepGate, wb_dat_i, wb_sel_i) & GATE_IMPL_MASK;
          end
          if (hitDeep) begin
            stateNext.deepGate = byte_merge(stateReg.deepGate, wb_dat_i, wb_sel_i) & GATE_IMPL_MASK;
          end
          if (hitCfg && wb_sel_i[AUTO_GATING_BIT[4:3]]) begin
            stateNext.autoGating = wb_dat_i[AUTO_GATING_BIT];
          end
        end
      end
      default: begin
        stateNext.busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateReg <= STATE_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_dat_o  = stateReg.datOut;
  assign wb_ack_o  = stateReg.ack;
  assign wb_err_o  = stateReg.err;
  assign unitClkEn = stateReg.gateEn;

  always_comb begin
    unitGate = '0;
    for (int i = 0; i < UNIT_COUNT; i++) begin
      unitGate[i] = stateReg.gateEn[unit_bit_pos(i[UNIT_IDX_W-1:0])];
    end
  end

  // ****************************************************************
  // fault on unclocked unit
  // ****************************************************************
  unit_access_guard #(
    .UNITS    (UNIT_COUNT)
  ) unit_access_guard_i (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .unitGate (unitGate),
    .accReq   (accReq),
    .accUnit  (accUnit),
    .accGrant (accGrant),
    .accFault (accFault)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_reset_clear;
    @(posedge sys_clk) rst |=> (stateReg.deepGate == 32'h0000_0000) && (unitClkEn == 32'h0000_0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("gates not zero after reset");

  property p_gate_follows;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> unitClkEn == ($past(selGate) & GATE_IMPL_MASK);
  endproperty
  a_gate_follows: assert property (p_gate_follows) else $error("clock enables do not follow selected gate");

  property p_run_when_no_auto;
    @(posedge sys_clk) disable iff (rst)
      (!stateReg.autoGating && deepSleepMode) ##1 !$past(rst) |-> unitClkEn == $past(stateReg.runGate);
  endproperty
  a_run_when_no_auto: assert property (p_run_when_no_auto) else $error("run gates not applied");

  property p_deep_when_auto;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.autoGating && deepSleepMode) ##1 !$past(rst) |-> unitClkEn == $past(stateReg.deepGate);
  endproperty
  a_deep_when_auto: assert property (p_deep_when_auto) else $error("deep gates not applied");

  property p_fault_unclocked;
    @(posedge sys_clk) disable iff (rst)
      (accReq && !unitGate[accUnit]) |=> accFault && !accGrant;
  endproperty
  a_fault_unclocked: assert property (p_fault_unclocked) else $error("no fault on unclocked unit");

  property p_grant_clocked;
    @(posedge sys_clk) disable iff (rst)
      (accReq && unitGate[accUnit]) |=> accGrant && !accFault;
  endproperty
  a_grant_clocked: assert property (p_grant_clocked) else $error("clocked unit access faulted");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (rst)
      wb_ack_o |-> (wb_dat_o & ~GATE_IMPL_MASK & ~(32'h0000_0001 << AUTO_GATING_BIT)) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_deep_write;
    @(posedge sys_clk) disable iff (rst)
      (writeNow && hitDeep && wb_sel_i == 4'hF) |=> stateReg.deepGate == ($past(wb_dat_i) & GATE_IMPL_MASK);
  endproperty
  a_deep_write: assert property (p_deep_write) else $error("deep gate write lost");

  property p_ack_latency;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.busState == BUS_IDLE && busReq) |=> (wb_ack_o ^ wb_err_o) ##1 !wb_ack_o && !wb_err_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("bus answer timing wrong");

  property p_unmapped_err;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.busState == BUS_IDLE && busReq && !mapped) |=> wb_err_o;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  // ****************************************************************
  // sleep selection, storage, read-back and guard checks
  // ****************************************************************
  property p_sleep_when_auto;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.autoGating && sleepMode && !deepSleepMode) ##1 !$past(rst)
      |-> unitClkEn == $past(stateReg.sleepGate);
  endproperty
  a_sleep_when_auto: assert property (p_sleep_when_auto) else $error("sleep gates not applied");

  property p_deep_reserved;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.deepGate & ~GATE_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_deep_reserved: assert property (p_deep_reserved) else $error("reserved deep gate bits stored");

  property p_enables_reserved;
    @(posedge sys_clk) disable iff (rst)
      (unitClkEn & ~GATE_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_enables_reserved: assert property (p_enables_reserved) else $error("enable on unimplemented bit");

  property p_err_no_write;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.busState == BUS_ANSWER && stateReg.err)
      |=> $stable(stateReg.deepGate) && $stable(stateReg.runGate);
  endproperty
  a_err_no_write: assert property (p_err_no_write) else $error("refused access changed a gate");

  property p_auto_write;
    @(posedge sys_clk) disable iff (rst)
      (writeNow && hitCfg && wb_sel_i[AUTO_GATING_BIT[4:3]])
      |=> stateReg.autoGating == $past(wb_dat_i[AUTO_GATING_BIT]);
  endproperty
  a_auto_write: assert property (p_auto_write) else $error("auto gating write lost");

  property p_read_data;
    @(posedge sys_clk) disable iff (rst)
      (stateReg.busState == BUS_IDLE && busReq && hitDeep && !wb_we_i)
      |=> wb_ack_o && wb_dat_o == $past(stateReg.deepGate);
  endproperty
  a_read_data: assert property (p_read_data) else $error("deep gate read data wrong");

  property p_guard_idle;
    @(posedge sys_clk) disable iff (rst)
      !$past(accReq) |-> !accGrant && !accFault;
  endproperty
  a_guard_idle: assert property (p_guard_idle) else $error("guard answer without request");

  property p_deep_hold;
    @(posedge sys_clk) disable iff (rst)
      !(writeNow && hitDeep) |=> $stable(stateReg.deepGate);
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep gate changed without write");

  c_deep_write:  cover property (@(posedge sys_clk) disable iff (rst) writeNow && hitDeep);
  c_fault:       cover property (@(posedge sys_clk) disable iff (rst) accFault);
  c_deep_active: cover property (@(posedge sys_clk) disable iff (rst)
                                 stateReg.autoGating && deepSleepMode && unitClkEn != 32'h0000_0000);
  c_unmapped:    cover property (@(posedge sys_clk) disable iff (rst) wb_err_o);
  c_sleep_active: cover property (@(posedge sys_clk) disable iff (rst)
                                  stateReg.autoGating && sleepMode && !deepSleepMode);

endmodule : deep_sleep_clock_gate_bank_one

// ===== clk_gate_pkg.sv
package clk_gate_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 12;
  localparam int          SEL_W           = 4;
  localparam int          UNIT_COUNT      = 8;
  localparam int          UNIT_IDX_W      = 3;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] RUN_CFG_OFF     = 12'h060;
  localparam logic [11:0] RUN_GATE_OFF    = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFF  = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFF   = 12'h124;
  localparam logic [11:0] GATE_STATUS_OFF = 12'h130;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam logic [4:0]  COMPARATOR_A_BIT   = 5'h18;
  localparam logic [4:0]  GP_COUNTER_C_BIT   = 5'h12;
  localparam logic [4:0]  GP_COUNTER_B_BIT   = 5'h11;
  localparam logic [4:0]  GP_COUNTER_A_BIT   = 5'h10;
  localparam logic [4:0]  TWO_WIRE_UNIT_BIT  = 5'h0C;
  localparam logic [4:0]  SYNC_SERIAL_BIT    = 5'h04;
  localparam logic [4:0]  ASYNC_SERIAL_B_BIT = 5'h01;
  localparam logic [4:0]  ASYNC_SERIAL_A_BIT = 5'h00;
  localparam logic [4:0]  AUTO_GATING_BIT    = 5'h1B;
  localparam logic [31:0] GATE_IMPL_MASK     = 32'h0107_1013;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] GATE_RESET      = 32'h0000_0000;
  localparam logic        AUTO_GATE_RESET = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

  // unit index to its gate bit
  function automatic logic [4:0] unit_bit_pos(input logic [UNIT_IDX_W-1:0] idx);
    case (idx)
      3'h0:    unit_bit_pos = ASYNC_SERIAL_A_BIT;
      3'h1:    unit_bit_pos = ASYNC_SERIAL_B_BIT;
      3'h2:    unit_bit_pos = SYNC_SERIAL_BIT;
      3'h3:    unit_bit_pos = TWO_WIRE_UNIT_BIT;
      3'h4:    unit_bit_pos = GP_COUNTER_A_BIT;
      3'h5:    unit_bit_pos = GP_COUNTER_B_BIT;
      3'h6:    unit_bit_pos = GP_COUNTER_C_BIT;
      default: unit_bit_pos = COMPARATOR_A_BIT;
    endcase
  endfunction : unit_bit_pos

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] byte_merge(input logic [31:0] oldWord,
                                             input logic [31:0] newWord,
                                             input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      byte_merge[b*8 +: 8] = sel[b] ? newWord[b*8 +: 8] : oldWord[b*8 +: 8];
    end
  endfunction : byte_merge

endpackage : clk_gate_pkg

// ===== unit_access_guard.sv
`timescale 1ns/1ps

module unit_access_guard
  import clk_gate_pkg::*;
#(
  parameter int UNITS = UNIT_COUNT
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [UNITS-1:0]      unitGate,
  input  wire logic                  accReq,
  input  wire logic [UNIT_IDX_W-1:0] accUnit,
  output logic                       accGrant,
  output logic                       accFault
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic grant;
    logic fault;
  } guard_state_t;

  guard_state_t guardReg;
  guard_state_t guardNext;
  logic         clocked;

  always_comb begin
    guardNext = guardReg;
    clocked   = unitGate[accUnit];
    // unclocked unit never completes, it faults instead
    guardNext.grant = accReq && clocked;
    guardNext.fault = accReq && !clocked;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      guardReg <= '0;
    end else begin
      guardReg <= guardNext;
    end
  end

  assign accGrant = guardReg.grant;
  assign accFault = guardReg.fault;

endmodule : unit_access_guard

// ===== deep_sleep_clock_gate_bank_one_tb.sv
`timescale 1ns/1ps

module deep_sleep_clock_gate_bank_one_tb;
  import clk_gate_pkg::*;

  logic                  sys_clk    = 1'b0;
  logic                  rst        = 1'b1;
  logic                  wbCyc      = 1'b0;
  logic                  wbStb      = 1'b0;
  logic                  wbWe       = 1'b0;
  logic [ADDR_W-1:0]     wbAdr      = 12'h000;
  logic [SEL_W-1:0]      wbSel      = 4'h0;
  logic [DATA_W-1:0]     wbDatW     = 32'h0000_0000;
  logic [DATA_W-1:0]     wbDatR;
  logic                  wbAck;
  logic                  wbErr;
  logic                  sleepM     = 1'b0;
  logic                  deepM      = 1'b0;
  logic [DATA_W-1:0]     clkEn;
  logic                  accReq     = 1'b0;
  logic [UNIT_IDX_W-1:0] accUnit    = 3'h0;
  logic                  accGrant;
  logic                  accFault;
  logic [DATA_W-1:0]     rdData;
  logic                  lastErr;
  int                    failCount  = 0;
  int                    numChecks  = 0;
  logic [4:0]            bitPos [8] = '{5'h00, 5'h01, 5'h04, 5'h0C, 5'h10, 5'h11, 5'h12, 5'h18};

  deep_sleep_clock_gate_bank_one deep_sleep_clock_gate_bank_one_i (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .wb_cyc_i      (wbCyc),
    .wb_stb_i      (wbStb),
    .wb_we_i       (wbWe),
    .wb_adr_i      (wbAdr),
    .wb_sel_i      (wbSel),
    .wb_dat_i      (wbDatW),
    .wb_dat_o      (wbDatR),
    .wb_ack_o      (wbAck),
    .wb_err_o      (wbErr),
    .sleepMode     (sleepM),
    .deepSleepMode (deepM),
    .unitClkEn     (clkEn),
    .accReq        (accReq),
    .accUnit       (accUnit),
    .accGrant      (accGrant),
    .accFault      (accFault)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // bench helpers
  // ****************************************************************
  task automatic summarize;
    if (failCount == 0 && numChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; request held until ack or err is sampled high
  task automatic wbAccess(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbSel  <= s;
    wbDatW <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
    rdData  = wbDatR;
    lastErr = wbErr;
    wbCyc  <= 1'b0;
    wbStb  <= 1'b0;
    wbWe   <= 1'b0;
    if (wbAck !== 1'b1 && wbErr !== 1'b1) begin
      failCount++;
      summarize();
    end
  endtask : wbAccess

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wbAccess(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    wbAccess(a, 1'b0, 32'h0000_0000, 4'hF);
  endtask : rd

  // enables register one cycle after their inputs change
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic modeChk(input logic s, input logic d, input logic [31:0] exp);
    @(posedge sys_clk);
    sleepM <= s;
    deepM  <= d;
    settle();
    check("unit clock enables", clkEn, exp);
  endtask : modeChk

  task automatic probe(input logic [2:0] idx, input logic granted);
    @(posedge sys_clk);
    accReq  <= 1'b1;
    accUnit <= idx;
    @(posedge sys_clk);
    accReq  <= 1'b0;
    #1;
    check("access grant", {31'h0, accGrant}, {31'h0, granted});
    check("access fault", {31'h0, accFault}, {31'h0, ~granted});
  endtask : probe

  initial begin
    repeat (100000) @(posedge sys_clk);
    failCount++;
    summarize();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(DEEP_GATE_OFF);
    check("deep gate reset", rdData, 32'h0000_0000);
    check("enables after reset", clkEn, 32'h0000_0000);
    rd(RUN_CFG_OFF);
    check("config reset", rdData, 32'h0000_0000);
    wr(DEEP_GATE_OFF, 32'hFFFF_FFFF);
    rd(DEEP_GATE_OFF);
    check("reserved bits read zero", rdData, 32'h0107_1013);
    wbAccess(DEEP_GATE_OFF, 1'b1, 32'h0000_0000, 4'h4);
    rd(DEEP_GATE_OFF);
    check("byte lane write", rdData, 32'h0100_1013);
    // unmapped neighbour must neither answer with ack nor disturb the gate
    wr(12'h128, 32'h0000_0000);
    check("unmapped write err", {31'h0, lastErr}, 32'h0000_0001);
    rd(12'h128);
    check("unmapped read err", {31'h0, lastErr}, 32'h0000_0001);
    check("unmapped read data", rdData, 32'h0000_0000);
    rd(DEEP_GATE_OFF);
    check("gate after unmapped", rdData, 32'h0100_1013);
    // distinct patterns show which bank drives the enables
    wr(RUN_GATE_OFF, 32'h0000_1000);
    wr(SLEEP_GATE_OFF, 32'h0001_0000);
    wr(DEEP_GATE_OFF, 32'h0100_0000);
    modeChk(1'b0, 1'b1, 32'h0000_1000);
    wr(RUN_CFG_OFF, 32'h0800_0000);
    rd(RUN_CFG_OFF);
    check("auto gating bit", rdData, 32'h0800_0000);
    modeChk(1'b0, 1'b1, 32'h0100_0000);
    modeChk(1'b1, 1'b1, 32'h0100_0000);
    modeChk(1'b1, 1'b0, 32'h0001_0000);
    modeChk(1'b0, 1'b0, 32'h0000_1000);
    modeChk(1'b0, 1'b1, 32'h0100_0000);
    // walk each gate alone in deep sleep
    for (int i = 0; i < 8; i++) begin
      wr(DEEP_GATE_OFF, 32'h0000_0001 << bitPos[i]);
      rd(DEEP_GATE_OFF);
      check("gate bit read back", rdData, 32'h0000_0001 << bitPos[i]);
      settle();
      check("single unit enable", clkEn, 32'h0000_0001 << bitPos[i]);
      probe(UNIT_IDX_W'(i), 1'b1);
      probe(UNIT_IDX_W'(i + 1), 1'b0);
    end
    wr(GATE_STATUS_OFF, 32'hFFFF_FFFF);
    rd(GATE_STATUS_OFF);
    check("status ignores write", rdData, 32'h0100_0000);
    wr(DEEP_GATE_OFF, 32'h0000_0000);
    settle();
    probe(3'h7, 1'b0);
    wr(DEEP_GATE_OFF, 32'h0107_1013);
    // second reset in mid-run clears every bank
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(DEEP_GATE_OFF);
    check("deep gate second reset", rdData, 32'h0000_0000);
    rd(RUN_CFG_OFF);
    check("config second reset", rdData, 32'h0000_0000);
    settle();
    check("enables second reset", clkEn, 32'h0000_0000);
    probe(3'h0, 1'b0);
    summarize();
  end

endmodule : deep_sleep_clock_gate_bank_one_tb
